//--- hw/vst_timing.sv
// 640x480 raster sync generator with pixel fifo and colour outputs
// assumes pixels arrive in raster order on a valid/ready stream, one clock
`timescale 1ns/1ps
module vst_timing #(
    parameter int unsigned H_VIS   = vst_pkg::H_VIS,
    parameter int unsigned H_FP    = vst_pkg::H_FP,
    parameter int unsigned H_PW    = vst_pkg::H_PW,
    parameter int unsigned H_BP    = vst_pkg::H_BP,
    parameter int unsigned V_VIS   = vst_pkg::V_VIS,
    parameter int unsigned V_FP    = vst_pkg::V_FP,
    parameter int unsigned V_PW    = vst_pkg::V_PW,
    parameter int unsigned V_BP    = vst_pkg::V_BP,
    parameter int unsigned FIFO_D  = vst_pkg::FIFO_DEPTH
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        px_valid,
    output logic                             px_ready,
    input  wire logic [vst_pkg::PIX_W-1:0]   px_data,
    output logic                             horiz_sync_out,
    output logic                             vert_sync_out,
    output logic [vst_pkg::CH_W-1:0]         red_out,
    output logic [vst_pkg::CH_W-1:0]         green_out,
    output logic [vst_pkg::CH_W-1:0]         blue_out,
    output logic [vst_pkg::CNT_W-1:0]        pix_col,
    output logic [vst_pkg::CNT_W-1:0]        pix_row,
    output logic [vst_pkg::ADDR_W-1:0]       pix_addr,
    output logic                             video_on,
    output logic                             frame_start,
    output logic                             underrun
);
    localparam int unsigned CW      = vst_pkg::CNT_W;
    localparam int unsigned H_TOT   = H_VIS + H_FP + H_PW + H_BP;
    localparam int unsigned V_TOT   = V_VIS + V_FP + V_PW + V_BP;
    localparam logic [CW-1:0] H_LAST  = CW'(H_TOT - 1);
    localparam logic [CW-1:0] V_LAST  = CW'(V_TOT - 1);
    localparam logic [CW-1:0] HS_BEG  = CW'(H_VIS + H_FP);
    localparam logic [CW-1:0] HS_END  = CW'(H_VIS + H_FP + H_PW);
    localparam logic [CW-1:0] VS_BEG  = CW'(V_VIS + V_FP);
    localparam logic [CW-1:0] VS_END  = CW'(V_VIS + V_FP + V_PW);
    localparam logic [vst_pkg::DIV_W-1:0] DIV_LAST =
        vst_pkg::DIV_W'(vst_pkg::PIX_DIV - 1);

    // pixel position is visible
    function automatic logic is_vis(input logic [CW-1:0] h, input logic [CW-1:0] v);
        is_vis = (h < CW'(H_VIS)) && (v < CW'(V_VIS));
    endfunction

    // linear memory address of a pixel
    function automatic logic [vst_pkg::ADDR_W-1:0] addr_of(input logic [CW-1:0] h,
                                                           input logic [CW-1:0] v);
        logic [vst_pkg::ADDR_W-1:0] a;
        a = vst_pkg::ADDR_W'(v) * vst_pkg::ADDR_W'(H_VIS);
        addr_of = a + vst_pkg::ADDR_W'(h);
    endfunction

    logic [vst_pkg::DIV_W-1:0]  div_r;
    logic                       tick;
    logic [CW-1:0]              h_r;
    logic [CW-1:0]              v_r;
    logic                       vis;
    logic                       fifo_valid;
    logic                       fifo_pop;
    logic [vst_pkg::PIX_W-1:0]  fifo_data;

    assign tick     = (div_r == DIV_LAST);
    assign vis      = is_vis(h_r, v_r);
    assign fifo_pop = tick && vis && fifo_valid;

    // pixel rate divider
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_r <= '0;
        end else begin
            div_r <= tick ? '0 : div_r + 1'b1;
        end
    end

    // column counter
    always_ff @(posedge mclk) begin
        if (rst) begin
            h_r <= '0;
        end else if (tick) begin
            h_r <= (h_r == H_LAST) ? '0 : h_r + 1'b1;
        end
    end

    // row counter, one step per line, origin at line start
    always_ff @(posedge mclk) begin
        if (rst) begin
            v_r <= '0;
        end else if (tick && h_r == H_LAST) begin
            v_r <= (v_r == V_LAST) ? '0 : v_r + 1'b1;
        end
    end

    // syncs, registered on the pixel slot edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            horiz_sync_out <= vst_pkg::SYNC_IDLE;
            vert_sync_out  <= vst_pkg::SYNC_IDLE;
        end else if (tick) begin
            horiz_sync_out <= !(h_r >= HS_BEG && h_r < HS_END);
            vert_sync_out  <= !(v_r >= VS_BEG && v_r < VS_END);
        end
    end

    // position and address of the pixel on the outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            pix_col     <= '0;
            pix_row     <= '0;
            pix_addr    <= '0;
            video_on    <= 1'b0;
            frame_start <= 1'b0;
        end else begin
            frame_start <= tick && h_r == '0 && v_r == '0;
            if (tick) begin
                pix_col  <= h_r;
                pix_row  <= v_r;
                pix_addr <= vis ? addr_of(h_r, v_r) : '0;
                video_on <= vis;
            end
        end
    end

    // colour: one fifo word per visible slot while the fifo has one, black on underrun and elsewhere
    always_ff @(posedge mclk) begin
        if (rst) begin
            red_out   <= '0;
            green_out <= '0;
            blue_out  <= '0;
            underrun  <= 1'b0;
        end else begin
            underrun <= tick && vis && !fifo_valid;
            if (tick) begin
                if (fifo_pop) begin
                    {red_out, green_out, blue_out} <= fifo_data;
                end else begin
                    red_out   <= '0;
                    green_out <= '0;
                    blue_out  <= '0;
                end
            end
        end
    end

    vst_fifo #(
        .W     (vst_pkg::PIX_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (px_valid),
        .in_ready  (px_ready),
        .in_data   (px_data),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // checking helpers: cycle counts between sync edges
    localparam int LINE_C  = int'(H_TOT * vst_pkg::PIX_DIV);
    localparam int HPW_C   = int'(H_PW * vst_pkg::PIX_DIV);
    localparam int VPW_C   = int'(V_PW) * LINE_C;
    localparam int FRAME_C = int'(V_TOT) * LINE_C;

    logic [21:0] hs_gap_r;
    logic [21:0] hs_low_r;
    logic [21:0] vs_gap_r;
    logic [21:0] vs_low_r;
    logic        hs_seen_r;
    logic        vs_seen_r;
    logic        hs_prev_r;
    logic        vs_prev_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            hs_gap_r  <= '0;
            hs_low_r  <= '0;
            vs_gap_r  <= '0;
            vs_low_r  <= '0;
            hs_seen_r <= 1'b0;
            vs_seen_r <= 1'b0;
            hs_prev_r <= 1'b1;
            vs_prev_r <= 1'b1;
        end else begin
            hs_prev_r <= horiz_sync_out;
            vs_prev_r <= vert_sync_out;
            hs_gap_r  <= (hs_prev_r && !horiz_sync_out) ? 22'h1 : hs_gap_r + 22'h1;
            vs_gap_r  <= (vs_prev_r && !vert_sync_out) ? 22'h1 : vs_gap_r + 22'h1;
            hs_low_r  <= horiz_sync_out ? '0 : hs_low_r + 22'h1;
            vs_low_r  <= vert_sync_out ? '0 : vs_low_r + 22'h1;
            if (hs_prev_r && !horiz_sync_out) begin
                hs_seen_r <= 1'b1;
            end
            if (vs_prev_r && !vert_sync_out) begin
                vs_seen_r <= 1'b1;
            end
        end
    end

    property p_pix_rate;
        @(posedge mclk) disable iff (rst)
        tick |=> !tick [*3] ##1 tick;
    endproperty
    a_pix_rate: assert property (p_pix_rate) else $error("pixel slot not 4 clocks");

    property p_line_len;
        @(posedge mclk) disable iff (rst)
        (hs_seen_r && hs_prev_r && !horiz_sync_out) |-> hs_gap_r == 22'(LINE_C);
    endproperty
    a_line_len: assert property (p_line_len) else $error("line length wrong");

    property p_hs_width;
        @(posedge mclk) disable iff (rst)
        $rose(horiz_sync_out) && hs_seen_r |-> hs_low_r == 22'(HPW_C);
    endproperty
    a_hs_width: assert property (p_hs_width) else $error("hsync width wrong");

    property p_vs_width;
        @(posedge mclk) disable iff (rst)
        $rose(vert_sync_out) && vs_seen_r |-> vs_low_r == 22'(VPW_C);
    endproperty
    a_vs_width: assert property (p_vs_width) else $error("vsync width wrong");

    property p_frame_len;
        @(posedge mclk) disable iff (rst)
        (vs_seen_r && vs_prev_r && !vert_sync_out) |-> vs_gap_r == 22'(FRAME_C);
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

    property p_blank;
        @(posedge mclk) disable iff (rst)
        !video_on |-> {red_out, green_out, blue_out} == '0;
    endproperty
    a_blank: assert property (p_blank) else $error("colour during blanking");

    property p_h_wrap;
        @(posedge mclk) disable iff (rst)
        (tick && h_r == H_LAST) |=> h_r == '0 && v_r != $past(v_r);
    endproperty
    a_h_wrap: assert property (p_h_wrap) else $error("column wrap or row step wrong");

    property p_v_step;
        @(posedge mclk) disable iff (rst)
        (tick && h_r != H_LAST) |=> v_r == $past(v_r);
    endproperty
    a_v_step: assert property (p_v_step) else $error("row moved mid line");

    property p_addr;
        @(posedge mclk) disable iff (rst)
        video_on |-> pix_addr == addr_of(pix_col, pix_row);
    endproperty
    a_addr: assert property (p_addr) else $error("address mismatch");

    property p_pop_slot;
        @(posedge mclk) disable iff (rst)
        fifo_pop |=> video_on && {red_out, green_out, blue_out} == $past(fifo_data);
    endproperty
    a_pop_slot: assert property (p_pop_slot) else $error("pixel not in its slot");

    property p_hs_pos;
        @(posedge mclk) disable iff (rst)
        !horiz_sync_out |-> pix_col >= HS_BEG && pix_col < HS_END;
    endproperty
    a_hs_pos: assert property (p_hs_pos) else $error("hsync outside pulse columns");

    property p_frame_cov;
        @(posedge mclk) disable iff (rst)
        frame_start;
    endproperty
    c_frame: cover property (p_frame_cov);

    property p_under_cov;
        @(posedge mclk) disable iff (rst)
        underrun;
    endproperty
    c_under: cover property (p_under_cov);

    property p_vs_cov;
        @(posedge mclk) disable iff (rst)
        $rose(vert_sync_out) && vs_seen_r;
    endproperty
    c_vsync: cover property (p_vs_cov);

endmodule // vst_timing

//--- hw/vst_pkg.sv
// raster timing constants for the 640x480 sync generator
// assumes a 100 MHz system clock and a 25 MHz pixel rate derived from it
package vst_pkg;

    // clocks
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned PIX_HZ     = 25_000_000;
    localparam int unsigned PIX_DIV    = CLK_HZ / PIX_HZ;
    localparam int unsigned DIV_W      = 2;

    // horizontal, in pixel clocks
    localparam int unsigned H_VIS      = 640;
    localparam int unsigned H_FP       = 16;
    localparam int unsigned H_PW       = 96;
    localparam int unsigned H_BP       = 48;
    localparam int unsigned H_TOTAL    = H_VIS + H_FP + H_PW + H_BP;

    // vertical, in lines
    localparam int unsigned V_VIS      = 480;
    localparam int unsigned V_FP       = 10;
    localparam int unsigned V_PW       = 2;
    localparam int unsigned V_BP       = 29;
    localparam int unsigned V_TOTAL    = V_VIS + V_FP + V_PW + V_BP;

    // printed times
    localparam int unsigned LINE_NS    = 32_000;
    localparam int unsigned LINE_CLKS  = LINE_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned FRAME_PIX  = 416_800;
    localparam int unsigned FRAME_CLKS = FRAME_PIX * PIX_DIV;

    // widths
    localparam int unsigned CNT_W      = 10;
    localparam int unsigned ADDR_W     = 19;
    localparam int unsigned CH_W       = 4;
    localparam int unsigned PIX_W      = 3 * CH_W;
    localparam int unsigned FIFO_DEPTH = 16;

    // reset values
    localparam logic        SYNC_IDLE  = 1'b1;

endpackage

//--- hw/vst_fifo.sv
// pixel word fifo, flop storage, registered full and empty
// assumes one clock, synchronous active high reset
`timescale 1ns/1ps
module vst_fifo #(
    parameter int unsigned W     = 12,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0]   cnt_r;
    logic [AW:0]   cnt_nxt;
    logic          push;
    logic          pop;

    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_r[rd_r];
    assign cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);

    // storage
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    // pointers
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
            end
        end
    end

    // occupancy and flags
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            in_ready  <= (cnt_nxt != (AW+1)'(DEPTH));
            out_valid <= (cnt_nxt != '0);
        end
    end

endmodule // vst_fifo

//--- dv/vst_monitor.sv
// far side: display measuring sync timing in mclk edges
// assumes active low syncs sampled on the rising mclk edge
`timescale 1ns/1ps
module vst_monitor (
    input  wire logic mclk,
    input  wire logic hsync_n,
    input  wire logic vsync_n,
    output int        line_clks,
    output int        hlow_clks,
    output int        frame_clks,
    output int        vlow_clks
);
    int   hc = 0, hl = 0, vc = 0, vl = 0;
    logic hs_q = 1'b1, vs_q = 1'b1;
    initial {line_clks, hlow_clks, frame_clks, vlow_clks} = '0;
    always @(posedge mclk) begin
        hc = hc + 1;
        vc = vc + 1;
        if (hs_q && !hsync_n) begin
            line_clks = hc;
            hc = 0;
        end
        if (!hs_q && hsync_n) hlow_clks = hl;
        if (vs_q && !vsync_n) begin
            frame_clks = vc;
            vc = 0;
        end
        if (!vs_q && vsync_n) vlow_clks = vl;
        hl = hsync_n ? 0 : hl + 1;
        vl = vsync_n ? 0 : vl + 1;
        hs_q = hsync_n;
        vs_q = vsync_n;
    end
endmodule // vst_monitor

//--- dv/vst_timing_tb.sv
// testbench: raster model with pixel queue, compared at every slot
// assumes 4 mclk per pixel slot and shrunk raster parameters
`timescale 1ns/1ps
module vst_timing_tb;
    localparam int HV = 8, HF = 2, HP = 3, HB = 2, HT = HV + HF + HP + HB;
    localparam int VV = 4, VF = 1, VP = 2, VB = 1, VT = VV + VF + VP + VB;
    localparam int FR = 4 * HT * VT;
    logic                          mclk = 1'b0, rst = 1'b1, px_valid = 1'b0;
    logic [vst_pkg::PIX_W-1:0]     px_data = '0;
    logic                          px_ready, hs, vs, video_on, frame_start, underrun;
    logic [vst_pkg::CH_W-1:0]      red_out, green_out, blue_out;
    logic [vst_pkg::CNT_W-1:0]     pix_col, pix_row;
    logic [vst_pkg::ADDR_W-1:0]    pix_addr;
    logic [31:0]                   rnd;
    logic [vst_pkg::PIX_W-1:0]     q[$];
    int bad_count = 0, checks_done = 0, tcnt = 0, eh = 0, ev = 0, refusals = 0, uruns = 0;
    int line_clks, hlow_clks, frame_clks, vlow_clks;
    bit feed = 0, dense = 1;

    always #5 mclk = ~mclk;

    vst_timing #(.H_VIS(HV), .H_FP(HF), .H_PW(HP), .H_BP(HB),
                 .V_VIS(VV), .V_FP(VF), .V_PW(VP), .V_BP(VB), .FIFO_D(16)) i_dut (
        .mclk(mclk), .rst(rst), .px_valid(px_valid), .px_ready(px_ready),
        .px_data(px_data), .horiz_sync_out(hs), .vert_sync_out(vs),
        .red_out(red_out), .green_out(green_out), .blue_out(blue_out),
        .pix_col(pix_col), .pix_row(pix_row), .pix_addr(pix_addr),
        .video_on(video_on), .frame_start(frame_start), .underrun(underrun));

    vst_monitor i_mon (.mclk(mclk), .hsync_n(hs), .vsync_n(vs), .line_clks(line_clks),
        .hlow_clks(hlow_clks), .frame_clks(frame_clks), .vlow_clks(vlow_clks));

    task automatic cmp(string what, logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s t=%0t got=%h exp=%h", what, $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp_timing;
        cmp("line", line_clks, 4 * HT);
        cmp("hlow", hlow_clks, 4 * HP);
        cmp("frame", frame_clks, FR);
        cmp("vlow", vlow_clks, 4 * HT * VP);
    endtask

    // source: holds a word until taken, random data
    always @(posedge mclk) begin
        bit acc, rs;
        acc = px_valid && px_ready;
        rs = rst;
        #1;
        if (acc || !px_valid) begin
            rnd = $urandom;
            px_valid = feed && !rs && (dense || rnd[31:30] != 2'b00);
            px_data = rnd[vst_pkg::PIX_W-1:0];
        end
    end

    // reference raster and fifo model
    always @(posedge mclk) begin
        bit push, rs, vis, un;
        logic [vst_pkg::PIX_W-1:0] d, xp;
        push = px_valid && px_ready;
        rs = rst;
        d = px_data;
        tcnt = rs ? 0 : tcnt + 1;
        #1;
        if (rs) begin
            q.delete();
            eh = HT - 1;
            ev = VT - 1;
            cmp("rst_out", {px_ready, hs, vs, red_out, green_out, blue_out, video_on},
                16'h6000);
            cmp("rst_pos", {pix_row, pix_col}, 0);
            cmp("rst_addr", pix_addr, 0);
        end else if (tcnt >= 4 && tcnt % 4 == 0) begin
            eh = (eh + 1) % HT;
            if (eh == 0) ev = (ev + 1) % VT;
            vis = eh < HV && ev < VV;
            un = vis && q.size() == 0;
            xp = (vis && !un) ? q.pop_front() : '0;
            if (un) uruns++;
            cmp("pos", {pix_row, pix_col}, {ev[9:0], eh[9:0]});
            cmp("vis", video_on, vis);
            cmp("hsync", hs, !(eh >= HV + HF && eh < HV + HF + HP));
            cmp("vsync", vs, !(ev >= VV + VF && ev < VV + VF + VP));
            cmp("colour", {red_out, green_out, blue_out}, xp);
            cmp("addr", pix_addr, vis ? ev * HV + eh : 0);
            cmp("pulses", {frame_start, underrun}, {eh == 0 && ev == 0, un});
        end else if (tcnt >= 4) begin
            cmp("hold", {pix_row, pix_col, frame_start, underrun}, {ev[9:0], eh[9:0], 2'b00});
        end
        if (!rs && tcnt > 2 && px_ready === 1'b0) refusals++;
        if (push && !rs) q.push_back(d);
        if (!rs) cmp("ready", px_ready, q.size() != 16);
        cmp("occ", q.size() > 16, 0);
    end

    initial begin
        rnd = $urandom(32'h5a1fe494);
        repeat (8) @(posedge mclk);
        #1 rst = 1'b0;
        feed = 1;
        repeat (2 * FR + 20) @(posedge mclk);
        cmp("refused", refusals > 0, 1);
        cmp_timing();
        $display("test fill done");
        feed = 0;
        dense = 0;
        repeat (FR) @(posedge mclk);
        cmp("underrun", uruns > 0, 1);
        feed = 1;
        repeat (FR + 37) @(posedge mclk);
        $display("test drain done");
        #1 rst = 1'b1;
        repeat (3) @(posedge mclk);
        #1 rst = 1'b0;
        dense = 1;
        repeat (2 * FR + 20) @(posedge mclk);
        cmp_timing();
        $display("test reset done");
        results();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        results();
    end
endmodule // vst_timing_tb
